// ==== plt_defines.vh ====
// Constants for the synthesizer digital control and lock detect block
`ifndef PLT_DEFINES_VH
`define PLT_DEFINES_VH

// Register byte addresses
`define PLT_ADDR_CTRL 8'h00
`define PLT_ADDR_RDIV 8'h04
`define PLT_ADDR_NUM 8'h08
`define PLT_ADDR_DEN 8'h0C
`define PLT_ADDR_STAT 8'h10

// Control register field positions
`define PLT_MUX_LSB 0
`define PLT_MUX_MSB 3
`define PLT_POL_BIT 4
`define PLT_DBL_BIT 5
`define PLT_WIDE_BIT 6
`define PLT_ORD_LSB 8
`define PLT_ORD_MSB 10
`define PLT_DITHER_STRENGTH_LSB 12
`define PLT_DITHER_STRENGTH_MSB 13
`define PLT_CPT_BIT 14
`define PLT_WIN_LSB 16
`define PLT_WIN_MSB 18

// Reset values
`define PLT_CTRL_RST 32'h0000_0040
`define PLT_RDIV_RST 12'h001
`define PLT_FRAC_RST 22'h00_0000

// Output selector codes
`define PLT_MUX_HIZ 4'h0
`define PLT_MUX_HIGH 4'h1
`define PLT_MUX_LOW 4'h2
`define PLT_MUX_LD 4'h3
`define PLT_MUX_LD_INV 4'h4
`define PLT_MUX_LD_OD 4'h5
`define PLT_MUX_N 4'h8
`define PLT_MUX_N_HALF 4'h9
`define PLT_MUX_R 4'hA
`define PLT_MUX_R_HALF 4'hB
`define PLT_MUX_UP 4'hC
`define PLT_MUX_DOWN 4'hD

// Modulator and dither codes
`define PLT_ORD_INT 3'h0
`define PLT_ORD_FIRST 3'h1
`define PLT_ORD_MAX 3'h4
`define PLT_DITHER_STRENGTH_OFF 2'h3

// Widths
`define PLT_FRAC_W 22
`define PLT_FRAC_NARROW_MASK 22'h00_03FF
`define PLT_CNT_W 16

// Timing: clock period and lock windows in picoseconds
`define PLT_CLK_PS 8000
`define PLT_WIN0_PS 3000
`define PLT_WIN1_PS 5500
`define PLT_WIN2_PS 8000
`define PLT_WIN3_PS 10500
`define PLT_WIN4_PS 13000
`define PLT_WIN5_PS 15500
`define PLT_LOCK_COUNT 3'h5
// Reference loss timeout in microseconds
`define PLT_REF_LOSS_US 64

// AHB codes
`define PLT_HTRANS_NONSEQ 2'h2
`define PLT_HTRANS_SEQ 2'h3

`endif

// ==== plt_core.v ====
// Synthesizer digital control: output mux, lock detector, phase detector
`timescale 1ns/1ps
`include "plt_defines.vh"

module plt_core #(
    parameter REF_LOSS_CYCLES = `PLT_REF_LOSS_US * 1000000 / `PLT_CLK_PS
) (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output reg [31:0] hrdata,
    output wire hresp,
    input wire ref_input,
    input wire n_div_pulse,
    output reg test_lock_out_pin_o,
    output reg test_lock_out_pin_oe_n,
    output reg pump_up,
    output reg pump_down,
    output reg pump_oe_n,
    output reg lock_detect,
    output reg [2:0] dsm_order,
    output reg int_mode,
    output reg analog_comp_en,
    output reg [1:0] dither_strength,
    output reg [21:0] frac_num,
    output reg [21:0] frac_den
);

    // Lock window in cycles; a longest time rounds down, floored at one
    function [`PLT_CNT_W-1:0] win_cycles;
        input [2:0] sel;
        integer ps;
        integer cyc;
        begin
            case (sel)
                3'h0: ps = `PLT_WIN0_PS;
                3'h1: ps = `PLT_WIN1_PS;
                3'h2: ps = `PLT_WIN2_PS;
                3'h3: ps = `PLT_WIN3_PS;
                3'h4: ps = `PLT_WIN4_PS;
                default: ps = `PLT_WIN5_PS; // Reserved codes act as widest
            endcase
            cyc = ps / `PLT_CLK_PS;
            if (cyc < 1) begin
                cyc = 1;
            end
            win_cycles = cyc[`PLT_CNT_W-1:0];
        end
    endfunction

    // Control registers
    reg [31:0] ctrl_q;
    reg [11:0] rdiv_q;
    reg [21:0] num_q;
    reg [21:0] den_q;

    wire [3:0] mux_sel = ctrl_q[`PLT_MUX_MSB:`PLT_MUX_LSB];
    wire pump_polarity = ctrl_q[`PLT_POL_BIT];
    wire ref_doubler_en = ctrl_q[`PLT_DBL_BIT];
    wire wide_fraction_en = ctrl_q[`PLT_WIDE_BIT];
    wire [2:0] order_sel = ctrl_q[`PLT_ORD_MSB:`PLT_ORD_LSB];
    wire [1:0] dither_sel = ctrl_q[`PLT_DITHER_STRENGTH_MSB:`PLT_DITHER_STRENGTH_LSB];
    wire pump_tristate = ctrl_q[`PLT_CPT_BIT];
    wire [2:0] lock_window_sel = ctrl_q[`PLT_WIN_MSB:`PLT_WIN_LSB];

    // AHB-Lite slave: zero wait states, always OKAY
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    wire addr_valid = hsel && hready &&
        (htrans == `PLT_HTRANS_NONSEQ || htrans == `PLT_HTRANS_SEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Read mux; unmapped addresses read zero
    reg [31:0] rd_d;
    always @* begin
        case (haddr[7:0])
            `PLT_ADDR_CTRL: rd_d = ctrl_q;
            `PLT_ADDR_RDIV: rd_d = {20'h0_0000, rdiv_q};
            `PLT_ADDR_NUM: rd_d = {10'h000, num_q};
            `PLT_ADDR_DEN: rd_d = {10'h000, den_q};
            `PLT_ADDR_STAT: rd_d = {24'h00_0000, analog_comp_en, int_mode,
                dsm_order, pump_oe_n, test_lock_out_pin_o, lock_detect};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Address phase capture and data-phase register writes
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            ctrl_q <= `PLT_CTRL_RST;
            rdiv_q <= `PLT_RDIV_RST;
            num_q <= `PLT_FRAC_RST;
            den_q <= `PLT_FRAC_RST;
        end else begin
            wr_pend_q <= addr_valid && hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_valid && !hwrite) begin
                hrdata <= rd_d;
            end
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `PLT_ADDR_CTRL: ctrl_q <= hwdata;
                    `PLT_ADDR_RDIV: rdiv_q <= hwdata[11:0];
                    `PLT_ADDR_NUM: num_q <= hwdata[21:0];
                    `PLT_ADDR_DEN: den_q <= hwdata[21:0];
                    default: ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

    // Reference edge detection; doubler fires on both edges
    reg ref_q;
    wire ref_rise = ref_input && !ref_q;
    wire ref_fall = !ref_input && ref_q;
    wire ref_evt = ref_doubler_en ? (ref_rise || ref_fall)
        : ref_rise;

    // R divider, bypassed while the doubler is on
    reg [11:0] rcnt_q;
    reg r_pulse;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 1'b0;
            rcnt_q <= 12'h000;
            r_pulse <= 1'b0;
        end else begin
            ref_q <= ref_input;
            r_pulse <= 1'b0;
            if (ref_evt) begin
                if (ref_doubler_en) begin
                    r_pulse <= 1'b1;
                    rcnt_q <= 12'h000;
                end else if (rcnt_q + 12'h001 >= rdiv_q) begin
                    r_pulse <= 1'b1;
                    rcnt_q <= 12'h000;
                end else begin
                    rcnt_q <= rcnt_q + 12'h001;
                end
            end
        end
    end

    // Phase-frequency detector; both set clears the pair
    reg pfd_r_q;
    reg pfd_n_q;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pfd_r_q <= 1'b0;
            pfd_n_q <= 1'b0;
        end else if ((pfd_r_q || r_pulse) && (pfd_n_q || n_div_pulse)) begin
            pfd_r_q <= 1'b0;
            pfd_n_q <= 1'b0;
        end else begin
            pfd_r_q <= pfd_r_q || r_pulse;
            pfd_n_q <= pfd_n_q || n_div_pulse;
        end
    end

    // Pump drive; polarity swaps the directions, tri-state floats it
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
            pump_oe_n <= 1'b1;
        end else begin
            pump_oe_n <= pump_tristate;
            if (pump_tristate) begin
                pump_up <= 1'b0;
                pump_down <= 1'b0;
            end else if (pump_polarity) begin
                pump_up <= pfd_n_q;
                pump_down <= pfd_r_q;
            end else begin
                pump_up <= pfd_r_q;
                pump_down <= pfd_n_q;
            end
        end
    end

    // Lock detector: count cycles between R and N edges
    reg meas_q;
    reg [`PLT_CNT_W-1:0] off_q;
    reg [2:0] good_q;
    reg [31:0] ref_idle_q;
    wire [`PLT_CNT_W-1:0] win = win_cycles(lock_window_sel);
    wire edge_any = r_pulse || n_div_pulse;
    wire edge_both = r_pulse && n_div_pulse;
    wire ref_lost = (ref_idle_q >= REF_LOSS_CYCLES);
    // An open offset running past the window counts as a bad cycle
    wire over = meas_q && (off_q >= win);
    wire close_ok = (meas_q && edge_any && off_q < win) || edge_both;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meas_q <= 1'b0;
            off_q <= {`PLT_CNT_W{1'b0}};
            good_q <= 3'h0;
            lock_detect <= 1'b0;
            ref_idle_q <= 32'h0000_0000;
        end else begin
            // Watchdog keeps lock honest when the reference dies
            if (ref_evt) begin
                ref_idle_q <= 32'h0000_0000;
            end else if (!ref_lost) begin
                ref_idle_q <= ref_idle_q + 32'h0000_0001;
            end
            if (ref_lost) begin
                lock_detect <= 1'b0;
                good_q <= 3'h0;
                meas_q <= 1'b0;
            end else if (over) begin
                lock_detect <= 1'b0;
                good_q <= 3'h0;
                meas_q <= 1'b0;
                off_q <= {`PLT_CNT_W{1'b0}};
            end else if (close_ok) begin
                meas_q <= 1'b0;
                off_q <= {`PLT_CNT_W{1'b0}};
                if (good_q + 3'h1 >= `PLT_LOCK_COUNT) begin
                    lock_detect <= 1'b1;
                    good_q <= `PLT_LOCK_COUNT;
                end else begin
                    good_q <= good_q + 3'h1;
                end
            end else if (edge_any) begin
                meas_q <= 1'b1;
                off_q <= {{(`PLT_CNT_W-1){1'b0}}, 1'b1};
            end else if (meas_q) begin
                off_q <= off_q + {{(`PLT_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Halved diagnostic outputs toggle per pulse for 50% duty
    reg n_half_q;
    reg r_half_q;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            n_half_q <= 1'b0;
            r_half_q <= 1'b0;
        end else begin
            if (n_div_pulse) begin
                n_half_q <= !n_half_q;
            end
            if (r_pulse) begin
                r_half_q <= !r_half_q;
            end
        end
    end

    // Output pin multiplexer; oe_n low while driving
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            test_lock_out_pin_o <= 1'b0;
            test_lock_out_pin_oe_n <= 1'b1;
        end else begin
            test_lock_out_pin_oe_n <= 1'b0;
            case (mux_sel)
                `PLT_MUX_HIGH: test_lock_out_pin_o <= 1'b1;
                `PLT_MUX_LOW: test_lock_out_pin_o <= 1'b0;
                `PLT_MUX_LD: test_lock_out_pin_o <= lock_detect;
                `PLT_MUX_LD_INV: test_lock_out_pin_o <= !lock_detect;
                `PLT_MUX_LD_OD: begin
                    // Pull low when unlocked, release when locked
                    test_lock_out_pin_o <= 1'b0;
                    test_lock_out_pin_oe_n <= lock_detect;
                end
                `PLT_MUX_N: test_lock_out_pin_o <= n_div_pulse;
                `PLT_MUX_N_HALF: test_lock_out_pin_o <= n_half_q;
                `PLT_MUX_R: test_lock_out_pin_o <= r_pulse;
                `PLT_MUX_R_HALF: test_lock_out_pin_o <= r_half_q;
                `PLT_MUX_UP: test_lock_out_pin_o <= pfd_r_q;
                `PLT_MUX_DOWN: test_lock_out_pin_o <= pfd_n_q;
                default: begin
                    // Code 0, analog and reserved codes leave the pin floating
                    test_lock_out_pin_o <= 1'b0;
                    test_lock_out_pin_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Modulator settings seen by the fractional engine
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dsm_order <= `PLT_ORD_INT;
            int_mode <= 1'b1;
            analog_comp_en <= 1'b0;
            dither_strength <= `PLT_DITHER_STRENGTH_OFF;
            frac_num <= `PLT_FRAC_RST;
            frac_den <= `PLT_FRAC_RST;
        end else begin
            // Illegal orders fall back to integer mode
            if (order_sel > `PLT_ORD_MAX) begin
                dsm_order <= `PLT_ORD_INT;
            end else begin
                dsm_order <= order_sel;
            end
            int_mode <= (order_sel == `PLT_ORD_INT) ||
                (order_sel > `PLT_ORD_MAX);
            analog_comp_en <= (order_sel > `PLT_ORD_FIRST) &&
                (order_sel <= `PLT_ORD_MAX);
            // Dither forced off where it would only add noise
            if (order_sel <= `PLT_ORD_FIRST || order_sel > `PLT_ORD_MAX) begin
                dither_strength <= `PLT_DITHER_STRENGTH_OFF;
            end else begin
                dither_strength <= dither_sel;
            end
            if (wide_fraction_en) begin
                frac_num <= num_q;
                frac_den <= den_q;
            end else begin
                frac_num <= num_q & `PLT_FRAC_NARROW_MASK;
                frac_den <= den_q & `PLT_FRAC_NARROW_MASK;
            end
        end
    end

endmodule

// ==== plt_core_assertions.sv ====
// Port-level checker for the synthesizer control and lock detect block
`timescale 1ns/1ps
module plt_core_checker #(
    parameter REF_LOSS_CYCLES = 50
) (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire hresp,
    input wire ref_input,
    input wire n_div_pulse,
    input wire lock_detect,
    input wire [2:0] dsm_order,
    input wire int_mode,
    input wire analog_comp_en,
    input wire [1:0] dither_strength
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    reg ref_q;
    reg [15:0] gap_q;
    reg [3:0] npl_q;

    // Cycles since a reference rise, and N pulses seen while unlocked
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 1'b0;
            gap_q <= 16'h0000;
            npl_q <= 4'h0;
        end else begin
            ref_q <= ref_input;
            if (ref_input && !ref_q)
                gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF)
                gap_q <= gap_q + 16'h0001;
            if (lock_detect)
                npl_q <= 4'h0;
            else if (n_div_pulse && npl_q != 4'hF)
                npl_q <= npl_q + 4'h1;
        end
    end

    dither_strength_off_a: assert property (dsm_order <= 3'h1
        |-> dither_strength == 2'h3)
        else $error("dither active in integer or first order");
    int_order_a: assert property (dsm_order == 3'h0 |-> int_mode)
        else $error("order zero without integer mode");
    frac_order_a: assert property ((dsm_order != 3'h0
        && dsm_order <= 3'h4) |-> !int_mode)
        else $error("fractional order flagged as integer");
    comp_first_a: assert property (dsm_order == 3'h1
        |-> !analog_comp_en)
        else $error("first order with analog compensation");
    lock_entry_a: assert property ($rose(lock_detect)
        |-> npl_q >= 4'h5)
        else $error("lock before five detector cycles");
    ref_loss_a: assert property (gap_q > REF_LOSS_CYCLES + 3
        |-> !lock_detect)
        else $error("lock kept with reference stopped");
    rdata_hold_a: assert property (!$stable(hrdata)
        |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("read data changed outside a read");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");

    lock_rise_c: cover property ($rose(lock_detect));
    lock_fall_c: cover property ($fell(lock_detect));
    order_four_c: cover property (dsm_order == 3'h4);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the synthesizer control and lock detect block
`timescale 1ns/1ps
`include "plt_defines.vh"
module testbench;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    reg hsel = 1'b1;
    reg hwrite = 1'b0;
    reg ref_input = 1'b0;
    reg n_div_pulse = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] haddr = 32'h0000_0000;
    reg [31:0] hwdata = 32'h0000_0000;
    wire hreadyout, hresp, pin_o, pin_oe_n, pump_up, pump_down, pump_oe_n;
    wire lock_detect, int_mode, analog_comp_en;
    wire [31:0] hrdata;
    wire [2:0] dsm_order;
    wire [1:0] dither_strength;
    wire [21:0] frac_num, frac_den;
    integer n_mismatch = 0;
    integer cmp_count = 0;
    integer i;
    reg [31:0] rd;

    // 125 MHz clock
    always #4 clock = ~clock;

    // Short reference-loss count keeps the stall scenario brief
    plt_core #(.REF_LOSS_CYCLES(50)) uut (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .ref_input(ref_input), .n_div_pulse(n_div_pulse),
        .test_lock_out_pin_o(pin_o), .test_lock_out_pin_oe_n(pin_oe_n),
        .pump_up(pump_up), .pump_down(pump_down), .pump_oe_n(pump_oe_n),
        .lock_detect(lock_detect), .dsm_order(dsm_order),
        .int_mode(int_mode), .analog_comp_en(analog_comp_en),
        .dither_strength(dither_strength), .frac_num(frac_num),
        .frac_den(frac_den));

    task stop_test;
        begin
            $display("Mismatches %0d comparisons %0d", n_mismatch, cmp_count);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                $display("Error %0s expected %h seen %h", nm, e, s);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task wait_rdy;
        integer k;
        begin
            k = 0;
            @(posedge clock);
            while (hreadyout !== 1'b1 && k < 40) begin
                @(posedge clock);
                k = k + 1;
            end
            if (k >= 40) begin
                n_mismatch = n_mismatch + 1;
                stop_test;
            end
        end
    endtask

    // Single word transfer; read data taken at the data phase edge
    task bus(input w, input [31:0] a, input [31:0] d, output [31:0] r);
        begin
            @(posedge clock); // Request always starts just after an edge
            haddr <= a;
            hwrite <= w;
            htrans <= `PLT_HTRANS_NONSEQ;
            wait_rdy;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy;
            r = hrdata;
        end
    endtask

    // Settings land one edge after the write; host keeps dither off
    // in integer and first order, as the modulator cannot use it there
    task wr_ctrl(input [31:0] d);
        begin
            if (d[`PLT_ORD_MSB:`PLT_ORD_LSB] <= `PLT_ORD_FIRST)
                d = d | 32'h0000_3000;
            bus(1'b1, `PLT_ADDR_CTRL, d, rd);
            repeat (2) @(posedge clock);
            #1;
        end
    endtask

    // Six-cycle reference periods; N pulse lands off cycles after the rise
    task ref_run(input integer periods, input integer off);
        integer p, c;
        begin
            for (p = 0; p < periods; p = p + 1) begin
                for (c = 0; c < 6; c = c + 1) begin
                    @(posedge clock);
                    ref_input <= (c < 3);
                    n_div_pulse <= (c == off);
                end
            end
            @(posedge clock);
            n_div_pulse <= 1'b0;
            repeat (2) @(posedge clock);
            #1;
        end
    endtask

    // Halved diagnostic must flip once per divider pulse
    task half_tog(input [3:0] code, input use_ref);
        begin
            wr_ctrl(32'h0000_0040 | code);
            rd[0] = pin_o;
            @(posedge clock);
            if (use_ref)
                ref_input <= 1'b1;
            else
                n_div_pulse <= 1'b1;
            @(posedge clock);
            ref_input <= 1'b0;
            n_div_pulse <= 1'b0;
            repeat (3) @(posedge clock);
            #1;
            chk("half_out", {31'h0, ~rd[0]}, {31'h0, pin_o});
            chk("half_oe_n", 32'h0, {31'h0, pin_oe_n});
        end
    endtask

    // A lone R edge holds its detector flag until an N pulse clears it
    task pump_dir(input [31:0] d, input [2:0] exp);
        begin
            wr_ctrl(d);
            @(posedge clock);
            ref_input <= 1'b1;
            @(posedge clock);
            ref_input <= 1'b0;
            repeat (4) @(posedge clock);
            #1;
            chk("pump_dir", {29'h0, exp},
                {29'h0, pump_up, pump_down, pin_o});
            @(posedge clock);
            n_div_pulse <= 1'b1;
            @(posedge clock);
            n_div_pulse <= 1'b0;
            repeat (4) @(posedge clock);
            #1;
            chk("pump_idle", 32'h0, {30'h0, pump_up, pump_down});
        end
    endtask

    // Count pin pulses over six reference periods with N pulses too
    task pulse_cnt(input [31:0] d, input [31:0] exp);
        integer p;
        reg [31:0] cnt;
        begin
            wr_ctrl(d);
            cnt = 32'h0;
            for (p = 0; p < 40; p = p + 1) begin
                @(posedge clock);
                ref_input <= (p < 36) && (p % 6 < 3);
                n_div_pulse <= (p < 36) && (p % 6 == 1);
                #1;
                cnt = cnt + {31'h0, pin_o};
            end
            chk("pulse_cnt", exp, cnt);
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, `PLT_ADDR_CTRL, 32'h0, rd);
        chk("ctrl_reset", `PLT_CTRL_RST, rd);
        bus(1'b0, 32'h0000_0020, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("dither_reset", 32'h3, {30'h0, dither_strength});
        for (i = 0; i < 4; i = i + 1) begin
            wr_ctrl(32'h0000_0040 | ((i == 3) ? 14 : i));
            chk("pin_oe_n", (i % 3) == 0, {31'h0, pin_oe_n});
            if (i == 1 || i == 2)
                chk("pin_level", (i == 1), {31'h0, pin_o});
        end
        half_tog(4'h9, 1'b0);
        half_tog(4'hB, 1'b1);
        wr_ctrl(32'h0000_0043);
        ref_run(4, 1);
        chk("lock_four", 32'h0, {31'h0, lock_detect});
        ref_run(1, 1);
        chk("lock_five", 32'h1, {31'h0, lock_detect});
        chk("pin_lock", 32'h1, {31'h0, pin_o});
        wr_ctrl(32'h0000_0044);
        chk("pin_inv", 32'h0, {31'h0, pin_o});
        wr_ctrl(32'h0000_0045);
        chk("od_release", 32'h1, {31'h0, pin_oe_n});
        repeat (60) @(posedge clock);
        #1;
        chk("ref_loss", 32'h0, {31'h0, lock_detect});
        chk("od_pull", 32'h0, {31'h0, pin_oe_n});
        ref_run(6, 1);
        ref_run(2, 4);
        chk("lock_exit", 32'h0, {31'h0, lock_detect});
        pump_dir(32'h0000_004C, 3'h5);
        pump_dir(32'h0000_005D, 3'h2);
        bus(1'b1, `PLT_ADDR_RDIV, 32'h0000_0003, rd);
        pulse_cnt(32'h0000_004A, 2);
        pulse_cnt(32'h0000_006A, 12);
        pulse_cnt(32'h0000_0048, 6);
        // Nonzero numerator before any dither is turned on
        bus(1'b1, `PLT_ADDR_NUM, 32'h003F_FFFF, rd);
        bus(1'b1, `PLT_ADDR_DEN, 32'h003F_FFFF, rd);
        for (i = 0; i < 4; i = i + 1) begin
            wr_ctrl(32'h0000_0240 | (i << 12));
            chk("dither", i, {30'h0, dither_strength});
        end
        wr_ctrl(32'h0000_0140);
        chk("first_dither_strength", 32'h3, {30'h0, dither_strength});
        chk("first_comp", 32'h0, {31'h0, analog_comp_en});
        wr_ctrl(32'h0000_0440);
        chk("order4", 32'h4, {29'h0, dsm_order});
        chk("order4_int", 32'h0, {31'h0, int_mode});
        wr_ctrl(32'h0000_0640);
        chk("illegal_int", 32'h1, {31'h0, int_mode});
        wr_ctrl(32'h0000_0200);
        chk("num_narrow", 32'h3FF, {10'h0, frac_num});
        chk("den_narrow", 32'h3FF, {10'h0, frac_den});
        wr_ctrl(32'h0000_0240);
        chk("num_wide", 32'h3F_FFFF, {10'h0, frac_num});
        chk("den_wide", 32'h3F_FFFF, {10'h0, frac_den});
        wr_ctrl(32'h0000_4040);
        chk("pump_float", 32'h1, {31'h0, pump_oe_n});
        wr_ctrl(32'h0000_0040);
        chk("pump_drive", 32'h0, {31'h0, pump_oe_n});
        stop_test;
    end
endmodule

bind plt_core plt_core_checker #(.REF_LOSS_CYCLES(REF_LOSS_CYCLES)) chk_i (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ref_input(ref_input),
    .n_div_pulse(n_div_pulse), .lock_detect(lock_detect),
    .dsm_order(dsm_order), .int_mode(int_mode),
    .analog_comp_en(analog_comp_en), .dither_strength(dither_strength));
